//--- verilog/ddr_rx_output.sv
// FIFO and DDR receive output path for pair buses C/D, E/F and line 9 of pair A/B.

// ----------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------
module ddr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid_i & in_ready_o;
   wire              pop  = out_valid_o & out_ready_i;
   wire              wr_wrap = (wr_q == AW'(DEPTH - 1));
   wire              rd_wrap = (rd_q == AW'(DEPTH - 1));

   assign in_ready_o  = (cnt_q != (AW + 1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_wrap ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_wrap ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   a_fifo_count_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cnt_q <= (AW + 1)'(DEPTH))
      else $error("FIFO count exceeds depth.");

   a_fifo_pop_empty: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (pop && !push && cnt_q == (AW + 1)'(1)) |=> !out_valid_o)
      else $error("FIFO not empty after last pop.");

   a_fifo_push_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (resetn_i && push && !pop) |=> cnt_q == $past(cnt_q) + (AW + 1)'(1))
      else $error("FIFO count missed a push.");
endmodule

// ----------------------------------------------------------------
// DDR receive output top
// ----------------------------------------------------------------
module ddr_rx_output
   import ddr_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic          clk_i,
   input  wire logic          resetn_i,
   input  wire logic          nibble_mode_i,
   input  wire logic          decode_sel_i,
   input  wire logic          rx_hold_i,
   input  wire logic          in_valid_i,
   output logic               in_ready_o,
   input  wire ddr_frame_type in_frame_i,
   output logic               rx_word_clock_o,
   output logic [BUS_W-1:0]   rx_pair_cd_bus_o,
   output logic [BUS_W-1:0]   rx_pair_ef_bus_o,
   output logic               rx_pair_ab_line9_o,
   output logic               rx_data_valid_o
);
   localparam int LINE_K_LO = 3;
   localparam int LINE_K_HI = 8;
   localparam int LINE_TOP  = 9;
   localparam int BIT_FOURTH = 3;
   localparam int BIT_FIFTH  = 4;
   localparam int DATA_MSB   = DATA_W - 1;
   localparam int DATA_MID   = DATA_W - 2;
   localparam int DATA_NIB   = DATA_W / 2;

   // ----------------------------------------------------------------
   // Buffer
   // ----------------------------------------------------------------
   logic               fifo_valid;
   logic [FRAME_W-1:0] fifo_data;
   logic               wclk_q;
   ddr_frame_type      cur_q;
   ddr_mode_type       mode_q;
   logic               valid_q;
   logic [BUS_W-1:0]   cd_q;
   logic [BUS_W-1:0]   ef_q;
   logic               ab9_q;

   // Words are taken only just before a falling half, so each frame starts falling.
   wire pop = wclk_q & fifo_valid & ~rx_hold_i;

   ddr_fifo #(
      .WIDTH (FRAME_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (in_valid_i),
      .in_ready_o  (in_ready_o),
      .in_data_i   (in_frame_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (pop),
      .out_data_o  (fifo_data)
   );

   // ----------------------------------------------------------------
   // Lane formatter
   // ----------------------------------------------------------------
   // Builds the ten lines of one pair bus for one half of the word clock.
   function automatic logic [BUS_W-1:0] ddr_pair_fmt(input ddr_chan_type lo,
                                                      input ddr_chan_type hi,
                                                      input logic         rise,
                                                      input ddr_mode_type mode);
      ddr_chan_type     sel;
      logic [BUS_W-1:0] r;
      sel = rise ? hi : lo;
      r   = BUS_IDLE;
      if (!mode.nibble) begin
         r = mode.decode ? {1'b0, sel.k, sel.data} : sel.code;
      end else if (!mode.decode) begin
         r[HALF_W-1:0]     = rise ? lo.code[BUS_W-1:HALF_W] : lo.code[HALF_W-1:0];
         r[BUS_W-1:HALF_W] = rise ? hi.code[BUS_W-1:HALF_W] : hi.code[HALF_W-1:0];
      end else begin
         r[HALF_W-1:0]     = rise ? {lo.data[DATA_MSB], lo.k, lo.data[DATA_MID:DATA_NIB]}
                                  : {1'b0, lo.data[DATA_NIB-1:0]};
         r[BUS_W-1:HALF_W] = rise ? {hi.data[DATA_MSB], hi.k, hi.data[DATA_MID:DATA_NIB]}
                                  : {1'b0, hi.data[DATA_NIB-1:0]};
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Next-half selection
   // ----------------------------------------------------------------
   wire ddr_mode_type  mode_in   = '{nibble: nibble_mode_i, decode: decode_sel_i};
   wire ddr_frame_type frame_nx  = wclk_q ? (pop ? ddr_frame_type'(fifo_data) : '0) : cur_q;
   wire ddr_mode_type  mode_nx   = (wclk_q && pop) ? mode_in : mode_q;
   wire                valid_nx  = wclk_q ? pop : valid_q;
   wire                rise_nx   = ~wclk_q;
   wire [BUS_W-1:0]    cd_nx     = ddr_pair_fmt(frame_nx.ch_c, frame_nx.ch_d, rise_nx, mode_nx);
   wire [BUS_W-1:0]    ef_nx     = ddr_pair_fmt(frame_nx.ch_e, frame_nx.ch_f, rise_nx, mode_nx);
   wire                ab9_mux   = rise_nx ? frame_nx.b_tenth : frame_nx.a_tenth;
   wire                ab9_nib   = rise_nx ? frame_nx.b_tenth : frame_nx.b_fifth;
   wire                ab9_nx    = mode_nx.decode ? 1'b0 : (mode_nx.nibble ? ab9_nib : ab9_mux);

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   // The word clock is the reference clock halved; every edge carries a new half.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wclk_q <= 1'b1;
      end else begin
         wclk_q <= ~wclk_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cur_q   <= '0;
         mode_q  <= '0;
         valid_q <= 1'b0;
         cd_q    <= BUS_IDLE;
         ef_q    <= BUS_IDLE;
         ab9_q   <= 1'b0;
      end else begin
         cur_q   <= frame_nx;
         mode_q  <= mode_nx;
         valid_q <= valid_nx;
         cd_q    <= cd_nx;
         ef_q    <= ef_nx;
         ab9_q   <= ab9_nx;
      end
   end

   assign rx_word_clock_o    = wclk_q;
   assign rx_pair_cd_bus_o   = cd_q;
   assign rx_pair_ef_bus_o   = ef_q;
   assign rx_pair_ab_line9_o = ab9_q;
   assign rx_data_valid_o    = valid_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   wire fall_v = valid_q & ~wclk_q;
   wire mux_raw = ~mode_q.nibble & ~mode_q.decode;
   wire mux_dec = ~mode_q.nibble & mode_q.decode;
   wire nib_raw = mode_q.nibble & ~mode_q.decode;
   wire nib_dec = mode_q.nibble & mode_q.decode;

   sequence s_nib_low_halves;
      cd_q[HALF_W-1:0] == cur_q.ch_c.code[HALF_W-1:0] ##1 cd_q[HALF_W-1:0] == cur_q.ch_c.code[BUS_W-1:HALF_W];
   endsequence

   sequence s_nib_top_lines;
      cd_q[LINE_TOP] == cur_q.ch_d.code[BIT_FIFTH] && cd_q[LINE_K_HI] == cur_q.ch_d.code[BIT_FOURTH]
      ##1 cd_q[LINE_TOP] == cur_q.ch_d.code[LINE_TOP] && cd_q[LINE_K_HI] == cur_q.ch_d.code[LINE_K_HI];
   endsequence

   sequence s_nib_dec_line8;
      ef_q[LINE_K_HI] == cur_q.ch_f.data[BIT_FOURTH] ##1 ef_q[LINE_K_HI] == cur_q.ch_f.k;
   endsequence

   sequence s_mux_cd_halves;
      cd_q == cur_q.ch_c.code ##1 cd_q == cur_q.ch_d.code;
   endsequence

   sequence s_mux_ef_halves;
      ef_q == cur_q.ch_e.code ##1 ef_q == cur_q.ch_f.code;
   endsequence

   sequence s_mux_k_halves;
      cd_q[LINE_K_HI] == cur_q.ch_c.k ##1 cd_q[LINE_K_HI] == cur_q.ch_d.k;
   endsequence

   sequence s_mux_dec_ef;
      ef_q == {1'b0, cur_q.ch_e.k, cur_q.ch_e.data} ##1 ef_q == {1'b0, cur_q.ch_f.k, cur_q.ch_f.data};
   endsequence

   sequence s_nib_cd_lanes;
      cd_q == {cur_q.ch_d.code[HALF_W-1:0], cur_q.ch_c.code[HALF_W-1:0]}
      ##1 cd_q == {cur_q.ch_d.code[BUS_W-1:HALF_W], cur_q.ch_c.code[BUS_W-1:HALF_W]};
   endsequence

   sequence s_line9_mux;
      ab9_q == cur_q.a_tenth ##1 ab9_q == cur_q.b_tenth;
   endsequence

   sequence s_line9_nib;
      ab9_q == cur_q.b_fifth ##1 ab9_q == cur_q.b_tenth;
   endsequence

   sequence s_frame_halves;
      valid_q && !wclk_q ##1 valid_q && wclk_q && $stable(mode_q) && $stable(cur_q);
   endsequence

   a_word_clock_toggle: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> wclk_q != $past(wclk_q))
      else $error("Word clock missed a toggle.");

   a_mux_cd_order: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && mux_raw) |-> s_mux_cd_halves)
      else $error("C/D bus order wrong in mux mode.");

   a_mux_ef_order: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && mux_raw) |-> s_mux_ef_halves)
      else $error("E/F bus order wrong in mux mode.");

   a_nib_low_halves: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_raw) |-> s_nib_low_halves)
      else $error("Nibble halves out of order.");

   a_nib_ef_lanes: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_raw) |-> ef_q == {cur_q.ch_f.code[HALF_W-1:0], cur_q.ch_e.code[HALF_W-1:0]})
      else $error("E/F nibble lanes wrong.");

   a_nib_lower_k: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_dec) |=> cd_q[LINE_K_LO] == cur_q.ch_c.k && ef_q[LINE_K_LO] == cur_q.ch_e.k)
      else $error("Lower channel K flag missing on line 3.");

   a_mux_raw_top: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (valid_q && wclk_q && mux_raw) |-> ef_q[LINE_K_HI] == cur_q.ch_f.code[LINE_K_HI]
                                       && ef_q[LINE_TOP] == cur_q.ch_f.code[LINE_TOP])
      else $error("Ninth or tenth bit misplaced.");

   a_mux_k_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && mux_dec) |-> s_mux_k_halves)
      else $error("Mux K flag wrong.");

   a_nib_top_lines: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_raw) |-> s_nib_top_lines)
      else $error("Upper channel lines 8 and 9 wrong.");

   a_nib_dec_line8: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_dec) |-> s_nib_dec_line8)
      else $error("Upper channel line 8 wrong when decoded.");

   a_pop_before_fall: assert property (@(posedge clk_i) disable iff (!resetn_i)
      pop |=> s_frame_halves)
      else $error("Frame not started on falling half.");

   a_decode_select: assert property (@(posedge clk_i) disable iff (!resetn_i)
      pop |=> mode_q.decode == $past(decode_sel_i))
      else $error("Decode select not applied.");

   a_nib_cd_lanes: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_raw) |-> s_nib_cd_lanes)
      else $error("C/D nibble lanes wrong.");

   a_nib_ef_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_raw) |=> ef_q == {cur_q.ch_f.code[BUS_W-1:HALF_W], cur_q.ch_e.code[BUS_W-1:HALF_W]})
      else $error("E/F upper nibbles wrong.");

   a_mux_dec_ef: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && mux_dec) |-> s_mux_dec_ef)
      else $error("E/F decoded words wrong.");

   a_line9_mux: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && mux_raw) |-> s_line9_mux)
      else $error("A/B line 9 wrong in mux mode.");

   a_line9_nib: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (fall_v && nib_raw) |-> s_line9_nib)
      else $error("A/B line 9 wrong in nibble mode.");

   a_line9_decoded: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (valid_q && mode_q.decode) |-> !ab9_q)
      else $error("A/B line 9 not low when decoded.");

   a_idle_lines: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !valid_q |-> cd_q == BUS_IDLE && ef_q == BUS_IDLE && !ab9_q)
      else $error("Bus not idle without data.");
endmodule

//--- inc/ddr_pkg.sv
// Package with constants and carrier types of the DDR receive output path.
package ddr_pkg;

   // ----------------------------------------------------------------
   // Widths, FIFO depth, clock period and idle value
   // ----------------------------------------------------------------
   localparam int BUS_W        = 10;
   localparam int HALF_W       = 5;
   localparam int DATA_W       = 8;
   localparam int FIFO_DEPTH   = 16;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [9:0] BUS_IDLE = 10'h000;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [BUS_W-1:0]  code;
      logic [DATA_W-1:0] data;
      logic              k;
   } ddr_chan_type;

   typedef struct packed {
      ddr_chan_type ch_c;
      ddr_chan_type ch_d;
      ddr_chan_type ch_e;
      ddr_chan_type ch_f;
      logic         a_tenth;
      logic         b_fifth;
      logic         b_tenth;
   } ddr_frame_type;

   localparam int FRAME_W = $bits(ddr_frame_type);

   typedef struct packed {
      logic nibble;
      logic decode;
   } ddr_mode_type;

endpackage

//--- testbench/ddr_rx_sink.sv
// Protocol device model that latches the pair buses and rebuilds each frame from its two halves.
module ddr_rx_sink
   import ddr_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             word_clock_i,
   input  wire logic [BUS_W-1:0] cd_i,
   input  wire logic [BUS_W-1:0] ef_i,
   input  wire logic             line9_i,
   input  wire logic             valid_i,
   output logic                  done_o,
   output logic [20:0]           fall_o,
   output logic [20:0]           rise_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Latch on both word clock edges, falling half first
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         done_o <= 1'b0;
         fall_o <= '0;
         rise_o <= '0;
      end else begin
         done_o <= 1'b0;
         if (valid_i && !word_clock_i) begin
            fall_o <= {line9_i, ef_i, cd_i};
         end
         if (valid_i && word_clock_i) begin
            rise_o <= {line9_i, ef_i, cd_i};
            done_o <= 1'b1;
         end
      end
   end
endmodule

//--- testbench/ddr_rx_output_test.sv
// Self-checking testbench of the DDR receive output path.
module ddr_rx_output_test
   import ddr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic          clk_i = 1'b0;
   logic          resetn_i = 1'b0;
   logic          nibble_mode_i = 1'b0;
   logic          decode_sel_i = 1'b0;
   logic          rx_hold_i = 1'b0;
   logic          in_valid_i = 1'b0;
   ddr_frame_type in_frame_i = '0;
   logic          in_ready, wclk, line9, dvalid, done;
   logic [9:0]    cd, ef;
   logic [20:0]   fall_w, rise_w, got;
   logic          rdy_s = 1'b1;
   logic          run = 1'b0;
   logic          wprev = 1'b1;
   logic [31:0]   seed = 32'h0000CC1F;
   logic [95:0]   tmp;
   logic [31:0]   v;
   ddr_frame_type q[$];
   ddr_frame_type f;
   int            error_cnt = 0;
   int            checked = 0;
   int            cyc = 0;

   always #25 clk_i = ~clk_i;

   ddr_rx_output #(.DEPTH(16)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .nibble_mode_i(nibble_mode_i),
      .decode_sel_i(decode_sel_i), .rx_hold_i(rx_hold_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready),
      .in_frame_i(in_frame_i), .rx_word_clock_o(wclk), .rx_pair_cd_bus_o(cd), .rx_pair_ef_bus_o(ef),
      .rx_pair_ab_line9_o(line9), .rx_data_valid_o(dvalid));

   ddr_rx_sink sink (.clk_i(clk_i), .resetn_i(resetn_i), .word_clock_i(wclk), .cd_i(cd), .ef_i(ef),
      .line9_i(line9), .valid_i(dvalid), .done_o(done), .fall_o(fall_w), .rise_o(rise_w));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [9:0] pb(ddr_chan_type lo, ddr_chan_type hi, logic r, logic n, logic d);
      if (!n) return d ? {1'b0, (r ? hi.k : lo.k), (r ? hi.data : lo.data)} : (r ? hi.code : lo.code);
      if (!d) return r ? {hi.code[9:5], lo.code[9:5]} : {hi.code[4:0], lo.code[4:0]};
      return r ? {hi.data[7], hi.k, hi.data[6:4], lo.data[7], lo.k, lo.data[6:4]}
               : {1'b0, hi.data[3:0], 1'b0, lo.data[3:0]};
   endfunction

   function automatic logic l9e(ddr_frame_type x, logic r, logic n, logic d);
      if (d) return 1'b0;
      return r ? x.b_tenth : (n ? x.b_fifth : x.a_tenth);
   endfunction

   task automatic chk(string name, logic [9:0] e, logic [9:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wait_drain();
      int n;
      n = 0;
      while (q.size() != 0 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      chk("drain", 10'h000, 10'(q.size()));
      repeat (2) @(posedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // Scoreboard and monitors
   // ----------------------------------------------------------------
   always @(negedge clk_i) rdy_s <= in_ready;

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_of_test();
      end
      if (in_valid_i && rdy_s && resetn_i) q.push_back(in_frame_i);
      if (done && q.size() == 0) chk("extra_frame", 10'h000, 10'h3FF);
      if (done && q.size() != 0) begin
         f = q.pop_front();
         for (int r = 0; r < 2; r++) begin
            got = r[0] ? rise_w : fall_w;
            chk("cd", pb(f.ch_c, f.ch_d, r[0], nibble_mode_i, decode_sel_i), got[9:0]);
            chk("ef", pb(f.ch_e, f.ch_f, r[0], nibble_mode_i, decode_sel_i), got[19:10]);
            chk("ab9", {9'h000, l9e(f, r[0], nibble_mode_i, decode_sel_i)}, {9'h000, got[20]});
         end
      end
      if (run) begin
         chk("wclk", {9'h000, ~wprev}, {9'h000, wclk});
         if (!dvalid) chk("idle", 10'h000, cd | ef | {9'h000, line9});
      end
      wprev <= wclk;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (19) @(posedge clk_i);
      @(negedge clk_i);
      chk("rst_out", 10'h003, {8'h00, wclk, in_ready} | cd | ef);
      @(posedge clk_i) resetn_i <= 1'b1;
      @(posedge clk_i) run <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_i);
         nibble_mode_i <= m[1];
         decode_sel_i <= m[0];
         repeat (48) begin
            @(posedge clk_i);
            v = rnd();
            tmp = {rnd(), rnd(), rnd()};
            in_valid_i <= v[1:0] != 2'b00;
            rx_hold_i <= v[3:2] == 2'b00;
            in_frame_i <= tmp[FRAME_W-1:0];
         end
         @(posedge clk_i);
         in_valid_i <= 1'b0;
         rx_hold_i <= 1'b0;
         wait_drain();
      end
      @(posedge clk_i) rx_hold_i <= 1'b1;
      repeat (20) begin
         @(posedge clk_i);
         tmp = {rnd(), rnd(), rnd()};
         in_valid_i <= 1'b1;
         in_frame_i <= tmp[FRAME_W-1:0];
      end
      @(negedge clk_i);
      chk("fill", 10'h010, {in_ready, 9'(q.size())});
      @(posedge clk_i);
      in_valid_i <= 1'b0;
      rx_hold_i <= 1'b0;
      wait_drain();
      end_of_test();
   end
endmodule
